// [hdl/cfg_access_pkg.sv]
// Purpose: shared constants for the tile configuration token protocol
// Assumes: byte-wide token stream, control flag marks control tokens
// Notes:   codes and field sizes live here; byte counts in cfg_req_end are literals
package cfg_access_pkg;
  // ***************************************************************
  // token codes
  // ***************************************************************
  localparam logic [7:0] TOK_WRITE = 8'hc0;  // 192
  localparam logic [7:0] TOK_READ  = 8'hc1;  // 193
  localparam logic [7:0] TOK_END   = 8'h01;
  localparam logic [7:0] TOK_ACK   = 8'h03;
  localparam logic [7:0] TOK_NACK  = 8'h04;
  // ***************************************************************
  // field sizes in bytes and the no-reply return byte
  // ***************************************************************
  localparam logic [2:0] RET_BYTES  = 3'h3;
  localparam logic [2:0] REG_BYTES  = 3'h2;
  localparam logic [2:0] DATA_BYTES = 3'h4;
  localparam logic [7:0] NOREPLY_LSB = 8'hff;
  // ***************************************************************
  // processor status resource id and register space
  // ***************************************************************
  localparam int         PS_SHIFT   = 8;
  localparam logic [7:0] PS_RES_LOW = 8'h0c;
  localparam int         NUM_REGS   = 16;
  // configuration endpoint low part for raw channel addressing
  localparam logic [15:0] CFG_EP_LOW = 16'hc20c;

  function automatic logic [31:0] ps_res_id(input logic [15:0] num);
    ps_res_id = ({16'h0000, num} << PS_SHIFT) | {24'h000000, PS_RES_LOW};
  endfunction
endpackage

// [hdl/cfg_link_if.sv]
`timescale 1ns/100ps
// Purpose: token link between requester and configuration end
// Assumes: single clock, valid/ready per byte, ctrl marks control token
// Notes:   two directions, request and reply
interface cfg_link_if;
  logic       req_valid;
  logic       req_ready;
  logic       req_ctrl;
  logic [7:0] req_data;
  logic       rsp_valid;
  logic       rsp_ready;
  logic       rsp_ctrl;
  logic [7:0] rsp_data;
  modport dev (input req_valid, req_ctrl, req_data, rsp_ready,
               output req_ready, rsp_valid, rsp_ctrl, rsp_data);
  modport req (output req_valid, req_ctrl, req_data, rsp_ready,
               input req_ready, rsp_valid, rsp_ctrl, rsp_data);
endinterface // cfg_link_if

// [hdl/cfg_dev_end.sv]
`timescale 1ns/100ps
// Purpose: configuration end that parses token requests and replies
// Assumes: link on clock_i, register file held locally
// Notes:   also exposes processor status resource id for local access
//
// Contract
// - request carries 24-bit return identifier
// - all-ones low return byte suppresses write reply
// - multi-byte fields go most significant first
// - status resource id is num shl 8 or 0x0C
// - status read and write move 32 bits
// - raw channel targets tile id plus c20C
// - read is 193, return, register, end
// - write replies 3,1 or 4,1
// - read replies 3, data, 1 or 4,1
// - write is 192, return, register, data, end
module cfg_dev_end (
  // clock and reset
  input  wire logic        clock_i,
  input  wire logic        sys_rst_i,
  input  wire logic        clk_en_i,
  // link
  cfg_link_if.dev          link,
  // processor local status access
  input  wire logic        ps_wr_i,
  input  wire logic [15:0] ps_num_i,
  input  wire logic [31:0] ps_wdata_i,
  output logic      [31:0] ps_rdata_o,
  output logic      [31:0] ps_res_id_o,
  // last request return identifier
  output logic      [23:0] ret_id_o
);
  // ***************************************************************
  // state
  // ***************************************************************
  typedef enum logic [2:0] {
    S_IDLE = 3'b000, S_RET = 3'b001, S_REG = 3'b011, S_DATA = 3'b010,
    S_END = 3'b110, S_RSP = 3'b111, S_SKIP = 3'b101
  } dev_state_e;

  dev_state_e  st_ff, nxt_st;
  logic        is_wr_ff, nxt_is_wr;
  logic        bad_ff, nxt_bad;
  logic [2:0]  cnt_ff, nxt_cnt;
  logic [23:0] ret_ff, nxt_ret;
  logic [15:0] reg_ff, nxt_reg;
  logic [31:0] dat_ff, nxt_dat;
  logic [2:0]  rsp_idx_ff, nxt_rsp_idx;
  logic [31:0] regs_ff [cfg_access_pkg::NUM_REGS];
  logic [31:0] ps_rdata_ff, ps_res_ff;
  logic        rd_v_ff, rd_c_ff;
  logic [7:0]  rd_d_ff;
  logic        nxt_rv, nxt_rc;
  logic [7:0]  nxt_rd;
  logic        in_fire, out_fire, reg_ok, ack;
  logic        do_wr;

  assign in_fire  = link.req_valid && link.req_ready;
  assign out_fire = rd_v_ff && link.rsp_ready;
  assign link.req_ready = (st_ff != S_RSP) && clk_en_i;
  assign reg_ok   = reg_ff < 16'(cfg_access_pkg::NUM_REGS);
  assign ack      = !bad_ff && reg_ok;

  // ***************************************************************
  // request parser and reply sequencer
  // ***************************************************************
  always_comb begin
    nxt_st = st_ff;
    nxt_is_wr = is_wr_ff;
    nxt_bad = bad_ff;
    nxt_cnt = cnt_ff;
    nxt_ret = ret_ff;
    nxt_reg = reg_ff;
    nxt_dat = dat_ff;
    nxt_rsp_idx = rsp_idx_ff;
    nxt_rv = rd_v_ff && !out_fire;
    nxt_rc = rd_c_ff;
    nxt_rd = rd_d_ff;
    do_wr = 1'b0;
    case (st_ff)
      S_IDLE: if (in_fire && link.req_ctrl) begin
        nxt_bad = 1'b0;
        nxt_cnt = cfg_access_pkg::RET_BYTES;
        if (link.req_data == cfg_access_pkg::TOK_WRITE) begin
          nxt_is_wr = 1'b1;
          nxt_st = S_RET;
        end else if (link.req_data == cfg_access_pkg::TOK_READ) begin
          nxt_is_wr = 1'b0;
          nxt_st = S_RET;
        end
      end
      S_RET, S_REG, S_DATA: if (in_fire) begin
        if (link.req_ctrl) begin
          // early control token: malformed, answer failure
          nxt_bad = 1'b1;
          nxt_st = (link.req_data == cfg_access_pkg::TOK_END) ? S_RSP
                                                              : S_SKIP;
          nxt_rsp_idx = 3'h0;
        end else begin
          nxt_cnt = cnt_ff - 3'h1;
          if (st_ff == S_RET)
            nxt_ret = {ret_ff[15:0], link.req_data};
          else if (st_ff == S_REG)
            nxt_reg = {reg_ff[7:0], link.req_data};
          else
            nxt_dat = {dat_ff[23:0], link.req_data};
          if (cnt_ff == 3'h1) begin
            if (st_ff == S_RET) begin
              nxt_st = S_REG;
              nxt_cnt = cfg_access_pkg::REG_BYTES;
            end else if (st_ff == S_REG && is_wr_ff) begin
              nxt_st = S_DATA;
              nxt_cnt = cfg_access_pkg::DATA_BYTES;
            end else
              nxt_st = S_END;
          end
        end
      end
      S_END: if (in_fire) begin
        nxt_rsp_idx = 3'h0;
        if (!(link.req_ctrl && link.req_data == cfg_access_pkg::TOK_END)) begin
          nxt_bad = 1'b1;
          nxt_st = link.req_ctrl ? S_RSP : S_SKIP;
        end else begin
          nxt_st = S_RSP;
          do_wr = is_wr_ff && reg_ok;
          if (is_wr_ff && ret_ff[7:0] == cfg_access_pkg::NOREPLY_LSB)
            nxt_st = S_IDLE;
        end
      end
      S_SKIP: if (in_fire && link.req_ctrl &&
                  link.req_data == cfg_access_pkg::TOK_END)
        nxt_st = S_RSP;
      S_RSP: if (!rd_v_ff || out_fire) begin
        nxt_rv = 1'b1;
        nxt_rsp_idx = rsp_idx_ff + 3'h1;
        if (rsp_idx_ff == 3'h0) begin
          nxt_rc = 1'b1;
          nxt_rd = ack ? cfg_access_pkg::TOK_ACK
                       : cfg_access_pkg::TOK_NACK;
        end else if (ack && !is_wr_ff && rsp_idx_ff < 3'h5) begin
          nxt_rc = 1'b0;
          nxt_rd = dat_ff[31:24];
          nxt_dat = {dat_ff[23:0], 8'h00};
        end else begin
          nxt_rc = 1'b1;
          nxt_rd = cfg_access_pkg::TOK_END;
          nxt_st = S_IDLE;
        end
      end
      default: nxt_st = S_IDLE;
    endcase
    // read data loaded as the closing token arrives
    if (st_ff == S_END && !is_wr_ff && reg_ok)
      nxt_dat = regs_ff[reg_ff[3:0]];
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      st_ff <= S_IDLE;
      is_wr_ff <= 1'b0;
      bad_ff <= 1'b0;
      cnt_ff <= 3'h0;
      ret_ff <= 24'h000000;
      reg_ff <= 16'h0000;
      dat_ff <= 32'h00000000;
      rsp_idx_ff <= 3'h0;
      rd_v_ff <= 1'b0;
      rd_c_ff <= 1'b0;
      rd_d_ff <= 8'h00;
    end else if (clk_en_i) begin
      st_ff <= nxt_st;
      is_wr_ff <= nxt_is_wr;
      bad_ff <= nxt_bad;
      cnt_ff <= nxt_cnt;
      ret_ff <= nxt_ret;
      reg_ff <= nxt_reg;
      dat_ff <= nxt_dat;
      rsp_idx_ff <= nxt_rsp_idx;
      rd_v_ff <= nxt_rv;
      rd_c_ff <= nxt_rc;
      rd_d_ff <= nxt_rd;
    end
  end

  // ***************************************************************
  // register file, link writes win over local status writes
  // ***************************************************************
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < cfg_access_pkg::NUM_REGS; i++)
        regs_ff[i] <= 32'h00000000;
      ps_rdata_ff <= 32'h00000000;
      ps_res_ff <= 32'h00000000;
    end else if (clk_en_i) begin
      if (do_wr)
        regs_ff[reg_ff[3:0]] <= dat_ff;
      else if (ps_wr_i && ps_num_i < 16'(cfg_access_pkg::NUM_REGS))
        regs_ff[ps_num_i[3:0]] <= ps_wdata_i;
      ps_rdata_ff <= (ps_num_i < 16'(cfg_access_pkg::NUM_REGS)) ?
                     regs_ff[ps_num_i[3:0]] : 32'h00000000;
      ps_res_ff <= cfg_access_pkg::ps_res_id(ps_num_i);
    end
  end

  assign link.rsp_valid = rd_v_ff;
  assign link.rsp_ctrl  = rd_c_ff;
  assign link.rsp_data  = rd_d_ff;
  assign ps_rdata_o  = ps_rdata_ff;
  assign ps_res_id_o = ps_res_ff;
  assign ret_id_o    = ret_ff;
endmodule // cfg_dev_end

// [hdl/cfg_req_end.sv]
`timescale 1ns/100ps
// Purpose: requester end that serialises config requests, collects replies
// Assumes: one request outstanding at a time
// Notes:   suppressed writes finish without waiting for a reply
module cfg_req_end (
  // clock and reset
  input  wire logic        clock_i,
  input  wire logic        sys_rst_i,
  input  wire logic        clk_en_i,
  // user request
  input  wire logic        start_i,
  input  wire logic        write_i,
  input  wire logic [23:0] ret_id_i,
  input  wire logic [15:0] reg_num_i,
  input  wire logic [31:0] wdata_i,
  // user answer
  output logic             busy_o,
  output logic             done_o,
  output logic             ok_o,
  output logic      [31:0] rdata_o,
  // link
  cfg_link_if.req          link
);
  typedef enum logic [1:0] {
    R_IDLE = 2'b00, R_SEND = 2'b01, R_WAIT = 2'b11
  } req_state_e;

  req_state_e  st_ff, nxt_st;
  logic [3:0]  idx_ff, nxt_idx;
  logic [71:0] msg_ff, nxt_msg;
  logic        wr_ff, nxt_wr, nor_ff, nxt_nor;
  logic        done_ff, nxt_done, ok_ff, nxt_ok;
  logic [31:0] rd_ff, nxt_rdv;
  logic        v_ff, nxt_v, c_ff, nxt_c;
  logic [7:0]  d_ff, nxt_d;
  logic        busy_ff, nxt_busy;
  logic [3:0]  last;

  // bytes: start token, 3 ret, 2 reg, 4 data (writes), end token
  assign last = wr_ff ? 4'ha : 4'h6;

  always_comb begin
    nxt_st = st_ff;
    nxt_idx = idx_ff;
    nxt_msg = msg_ff;
    nxt_wr = wr_ff;
    nxt_nor = nor_ff;
    nxt_done = 1'b0;
    nxt_ok = ok_ff;
    nxt_rdv = rd_ff;
    nxt_v = v_ff && !link.req_ready;
    nxt_c = c_ff;
    nxt_d = d_ff;
    case (st_ff)
      R_IDLE: if (start_i) begin
        nxt_wr = write_i;
        nxt_nor = write_i &&
                  ret_id_i[7:0] == cfg_access_pkg::NOREPLY_LSB;
        nxt_msg = {ret_id_i, reg_num_i, wdata_i};
        nxt_idx = 4'h0;
        nxt_st = R_SEND;
      end
      R_SEND: if (!v_ff || link.req_ready) begin
        nxt_v = 1'b1;
        nxt_idx = idx_ff + 4'h1;
        if (idx_ff == 4'h0) begin
          nxt_c = 1'b1;
          nxt_d = wr_ff ? cfg_access_pkg::TOK_WRITE
                        : cfg_access_pkg::TOK_READ;
        end else if (idx_ff == last) begin
          nxt_c = 1'b1;
          nxt_d = cfg_access_pkg::TOK_END;
          nxt_st = R_WAIT;
        end else begin
          nxt_c = 1'b0;
          nxt_d = msg_ff[71:64];
          nxt_msg = {msg_ff[63:0], 8'h00};
        end
      end
      R_WAIT: if (!v_ff || link.req_ready) begin
        if (nor_ff && !v_ff) begin
          nxt_st = R_IDLE;
          nxt_done = 1'b1;
          nxt_ok = 1'b1;
        end else if (!nor_ff && link.rsp_valid) begin
          if (link.rsp_ctrl) begin
            if (link.rsp_data == cfg_access_pkg::TOK_ACK)
              nxt_ok = 1'b1;
            else if (link.rsp_data == cfg_access_pkg::TOK_NACK)
              nxt_ok = 1'b0;
            else if (link.rsp_data == cfg_access_pkg::TOK_END) begin
              nxt_st = R_IDLE;
              nxt_done = 1'b1;
            end
          end else
            nxt_rdv = {rd_ff[23:0], link.rsp_data};
        end
      end
      default: nxt_st = R_IDLE;
    endcase
    // busy is registered so that the port comes straight from a flop
    nxt_busy = (nxt_st != R_IDLE);
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      st_ff <= R_IDLE;
      idx_ff <= 4'h0;
      msg_ff <= 72'h0;
      wr_ff <= 1'b0;
      nor_ff <= 1'b0;
      done_ff <= 1'b0;
      ok_ff <= 1'b0;
      rd_ff <= 32'h00000000;
      v_ff <= 1'b0;
      c_ff <= 1'b0;
      d_ff <= 8'h00;
      busy_ff <= 1'b0;
    end else if (clk_en_i) begin
      st_ff <= nxt_st;
      idx_ff <= nxt_idx;
      msg_ff <= nxt_msg;
      wr_ff <= nxt_wr;
      nor_ff <= nxt_nor;
      done_ff <= nxt_done;
      ok_ff <= nxt_ok;
      rd_ff <= nxt_rdv;
      v_ff <= nxt_v;
      c_ff <= nxt_c;
      d_ff <= nxt_d;
      busy_ff <= nxt_busy;
    end
  end

  assign link.req_valid = v_ff;
  assign link.req_ctrl  = c_ff;
  assign link.req_data  = d_ff;
  assign link.rsp_ready = (st_ff == R_WAIT) && clk_en_i;
  assign busy_o  = busy_ff;
  assign done_o  = done_ff;
  assign ok_o    = ok_ff;
  assign rdata_o = rd_ff;
endmodule // cfg_req_end

// [tb/cfg_access_chk.sv]
// Purpose: link watcher for the configuration token exchange
// Assumes: one clock domain, synchronous active-high reset
// Notes:   helpers count bytes so that order and length can be judged
`timescale 1ns/100ps
module cfg_access_chk (
  // clock and reset
  input wire logic       clock_i,
  input wire logic       sys_rst_i,
  // link
  input wire logic       req_valid,
  input wire logic       req_ready,
  input wire logic       req_ctrl,
  input wire logic [7:0] req_data,
  input wire logic       rsp_valid,
  input wire logic       rsp_ready,
  input wire logic       rsp_ctrl,
  input wire logic [7:0] rsp_data
);
  // ************************************************************
  // message trackers
  // ************************************************************
  logic       wr_ff;
  logic       first_ff;
  logic       nack_ff;
  logic [3:0] cnt_ff;
  logic [3:0] dcnt_ff;
  logic [7:0] lsb_ff;
  wire        rx    = req_valid && req_ready;
  wire        tx    = rsp_valid && rsp_ready;
  wire        rend  = rx && req_ctrl && req_data == cfg_access_pkg::TOK_END;
  wire        quiet = wr_ff && lsb_ff == cfg_access_pkg::NOREPLY_LSB;
  // cnt_ff of 4'hf marks idle so a junk-free opener can be judged
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      wr_ff    <= 1'b0;
      first_ff <= 1'b1;
      nack_ff  <= 1'b0;
      cnt_ff   <= 4'hf;
      dcnt_ff  <= 4'h0;
      lsb_ff   <= 8'h00;
    end else begin
      if (rx) begin
        cnt_ff <= rend ? 4'hf : req_ctrl ? 4'h0 : cnt_ff + 4'h1;
        wr_ff  <= req_ctrl && !rend ? req_data[0] == 1'b0 : wr_ff;
        lsb_ff <= !req_ctrl && cnt_ff == 4'h2 ? req_data : lsb_ff;
      end
      if (tx) begin
        first_ff <= rsp_ctrl && rsp_data == cfg_access_pkg::TOK_END;
        nack_ff  <= first_ff ? rsp_data == cfg_access_pkg::TOK_NACK : nack_ff;
        dcnt_ff  <= rsp_ctrl ? 4'h0 : dcnt_ff + 4'h1;
      end
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  AST_REQ_START: assert property (rx && cnt_ff == 4'hf |-> req_ctrl &&
    (req_data == cfg_access_pkg::TOK_WRITE || req_data == 8'hc1))
    else $error("request opened without an operation token");
  AST_REQ_LEN: assert property (rend |-> cnt_ff == (wr_ff ? 4'h9 : 4'h5))
    else $error("request closed after a wrong byte count");
  AST_REQ_HOLD: assert property (req_valid && !req_ready |=>
    req_valid && $stable({req_ctrl, req_data}))
    else $error("request byte changed before it was taken");
  AST_RSP_HOLD: assert property (rsp_valid && !rsp_ready |=>
    rsp_valid && $stable({rsp_ctrl, rsp_data}))
    else $error("reply byte changed before it was taken");
  AST_RSP_FIRST: assert property (tx && first_ff |-> rsp_ctrl &&
    (rsp_data == cfg_access_pkg::TOK_ACK || rsp_data == 8'h04))
    else $error("reply did not open with a status token");
  AST_RSP_BODY: assert property (tx && !first_ff |-> (rsp_ctrl ?
    rsp_data == 8'h01 && dcnt_ff == (nack_ff || wr_ff ? 4'h0 : 4'h4) :
    !nack_ff && !wr_ff && dcnt_ff < 4'h4))
    else $error("reply body has a wrong length or closing");
  AST_REPLY_TIME: assert property (rend && !quiet |-> ##[1:2] rsp_valid)
    else $error("reply did not start in time");
  AST_NO_REPLY: assert property (rend && quiet |=> !rsp_valid [*4])
    else $error("silenced write was answered");
endmodule // cfg_access_chk

// [tb/tile_config_access_protocol_tb.sv]
// Purpose: end-to-end bench for the configuration token ends
// Assumes: one clock; a second device end faces the bench directly
// Notes:   the bench end breaks message framing on purpose
`timescale 1ns/100ps
module tile_config_access_protocol_tb;
  logic        clock_i, sys_rst_i, clk_en_i, start_i, write_i, ps_wr_i;
  logic        busy_o, done_o, ok_o;
  logic        mon_clr;
  logic [15:0] reg_num_i, ps_num_i;
  logic [23:0] ret_id_i, ret_id_o;
  logic [31:0] wdata_i, ps_wdata_i, rdata_o, ps_rdata_o, ps_res_id_o;
  logic [31:0] mem [16];
  logic [95:0] rqv, rsv, r2v, v;
  int          errors, comparisons, seed, i;
  cfg_link_if  lk ();
  cfg_link_if  lk2 ();
  cfg_req_end cfg_req_end_i (.clock_i, .sys_rst_i, .clk_en_i, .start_i,
    .write_i, .ret_id_i, .reg_num_i, .wdata_i, .busy_o, .done_o, .ok_o,
    .rdata_o, .link(lk));
  cfg_dev_end cfg_dev_end_i (.clock_i, .sys_rst_i, .clk_en_i, .link(lk),
    .ps_wr_i, .ps_num_i, .ps_wdata_i, .ps_rdata_o, .ps_res_id_o, .ret_id_o);
  cfg_dev_end cfg_dev_end_i2 (.clock_i, .sys_rst_i, .clk_en_i, .link(lk2),
    .ps_wr_i, .ps_num_i, .ps_wdata_i, .ps_rdata_o(), .ps_res_id_o(),
    .ret_id_o());
  cfg_access_chk cfg_access_chk_i (.clock_i, .sys_rst_i,
    .req_valid(lk.req_valid), .req_ready(lk.req_ready),
    .req_ctrl(lk.req_ctrl), .req_data(lk.req_data),
    .rsp_valid(lk.rsp_valid), .rsp_ready(lk.rsp_ready),
    .rsp_ctrl(lk.rsp_ctrl), .rsp_data(lk.rsp_data));
  // ************************************************************
  // wire monitors, random reply stalls on the bench end
  // ************************************************************
  always @(posedge clock_i) begin
    lk2.rsp_ready <= 1'($random(seed));
    // monitors are cleared here only, so each has a single driver
    if (mon_clr) begin
      {rqv, rsv, r2v} <= '0;
    end else begin
      if (lk.req_valid && lk.req_ready)
        rqv <= {rqv[86:0], lk.req_ctrl, lk.req_data};
      if (lk.rsp_valid && lk.rsp_ready)
        rsv <= {rsv[86:0], lk.rsp_ctrl, lk.rsp_data};
      if (lk2.rsp_valid && lk2.rsp_ready)
        r2v <= {r2v[86:0], lk2.rsp_ctrl, lk2.rsp_data};
    end
  end
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  // appends n bytes of x, most significant first, each with flag c
  function automatic logic [95:0] app(logic [95:0] v, logic c,
                                      logic [63:0] x, int n);
    for (int k = n - 1; k >= 0; k--) v = {v[86:0], c, x[8*k+:8]};
    return v;
  endfunction
  function automatic logic [95:0] ct(logic [95:0] v, logic [7:0] t);
    return app(v, 1'b1, {56'h0, t}, 1);
  endfunction
  task automatic chk(string nm, logic [95:0] e, logic [95:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic xact(logic w, logic [23:0] r, logic [15:0] g,
                      logic [31:0] d);
    logic [95:0] e;
    logic        ok;
    ok = g < 16'h0010;
    e = ct(96'h0, w ? cfg_access_pkg::TOK_WRITE : cfg_access_pkg::TOK_READ);
    e = app(e, 1'b0, {24'h0, r, g}, 5);
    if (w) e = app(e, 1'b0, {32'h0, d}, 4);
    mon_clr <= 1'b1;
    @(posedge clock_i);
    mon_clr <= 1'b0;
    {start_i, write_i, ret_id_i, reg_num_i, wdata_i} <= {1'b1, w, r, g, d};
    @(posedge clock_i);
    start_i <= 1'b0;
    @(negedge clock_i);
    chk("busy", 96'h1, 96'(busy_o));
    for (int k = 0; k < 200 && done_o !== 1'b1; k++) @(negedge clock_i);
    chk("request", ct(e, 8'h01), rqv);
    chk("return id", 96'(r), 96'(ret_id_o));
    if (w && r[7:0] == 8'hff) begin
      repeat (6) @(negedge clock_i);
      chk("silenced reply", 96'h0, rsv);
    end else begin
      chk("ok", 96'(ok), 96'(ok_o));
      e = ct(96'h0, ok ? 8'h03 : 8'h04);
      if (ok && !w) e = app(e, 1'b0, {32'h0, mem[g[3:0]]}, 4);
      if (ok && !w) chk("rdata", 96'(mem[g[3:0]]), 96'(rdata_o));
      chk("reply", ct(e, 8'h01), rsv);
    end
    if (ok && w) mem[g[3:0]] = d;
  endtask
  // bench end: holds each byte until taken, scrambles data when idle
  task automatic send2(logic [95:0] m, int n, logic [95:0] e);
    mon_clr <= 1'b1;
    @(posedge clock_i);
    mon_clr <= 1'b0;
    for (int k = n - 1; k >= 0; k--) begin
      {lk2.req_valid, lk2.req_ctrl, lk2.req_data} <= {1'b1, m[9*k+:9]};
      @(posedge clock_i);
      while (lk2.req_ready !== 1'b1) @(posedge clock_i);
    end
    {lk2.req_valid, lk2.req_data} <= {1'b0, ~lk2.req_data};
    repeat (40) @(negedge clock_i);
    chk("framing reply", e, r2v);
  endtask
  task automatic close_out();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge clock_i);
    errors++;
    close_out();
  end
  initial begin
    {seed, errors, comparisons, sys_rst_i, clk_en_i} = {32'h20, 64'h0, 2'h3};
    {start_i, write_i, ret_id_i, reg_num_i, wdata_i} = '0;
    {ps_wr_i, ps_num_i, ps_wdata_i} = '0;
    {lk2.req_valid, lk2.req_ctrl, lk2.req_data} = '0;
    mon_clr = 1'b1;
    for (i = 0; i < 16; i++) mem[i] = 32'h0;
    repeat (16) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    @(negedge clock_i);
    chk("reset", 96'h0, {8'h00, ret_id_o, rdata_o, ps_res_id_o});
    chk("endpoint", 96'h1234c20c,
        96'({16'h1234, cfg_access_pkg::CFG_EP_LOW}));
    for (i = 0; i < 20; i++) begin
      @(posedge clock_i);
      {ps_wr_i, ps_wdata_i} <= {1'b1, 32'($random(seed))};
      ps_num_i <= 16'($unsigned($random(seed)) % 18);
      @(posedge clock_i);
      ps_wr_i <= 1'b0;
      if (ps_num_i < 16'h0010) mem[ps_num_i[3:0]] = ps_wdata_i;
      repeat (2) @(negedge clock_i);
      chk("res id", 96'({8'h00, ps_num_i, 8'h0c}), 96'(ps_res_id_o));
      if (ps_num_i < 16'h0010)
        chk("status", 96'(mem[ps_num_i[3:0]]), 96'(ps_rdata_o));
    end
    // enable low: a local write must not land and outputs must hold
    i = ps_num_i;
    @(posedge clock_i);
    {clk_en_i, ps_wr_i, ps_num_i} <= {1'b0, 1'b1, 16'h0005};
    ps_wdata_i <= ~mem[5];
    repeat (2) @(negedge clock_i);
    chk("frozen res id", 96'({8'h00, 16'(i), 8'h0c}), 96'(ps_res_id_o));
    @(posedge clock_i);
    {clk_en_i, ps_wr_i} <= 2'h2;
    repeat (2) @(negedge clock_i);
    chk("frozen write", 96'(mem[5]), 96'(ps_rdata_o));
    v = ct(ct(app(96'h0, 1'b0, 64'h55, 1), 8'h7e), 8'hc1);
    v = ct(app(v, 1'b0, 64'h0a0b0c0003, 5), 8'h01);
    send2(v, 9, ct(app(ct(96'h0, 8'h03), 1'b0, 64'(mem[3]), 4), 8'h01));
    v = ct(ct(app(ct(96'h0, 8'hc0), 1'b0, 64'h0a0b0c00, 4), 8'hc1), 8'h01);
    send2(v, 7, ct(ct(96'h0, 8'h04), 8'h01));
    v = ct(app(ct(96'h0, 8'hc1), 1'b0, 64'h0a0b0c000177, 6), 8'h01);
    send2(v, 8, ct(ct(96'h0, 8'h04), 8'h01));
    xact(1'b1, 24'h0123ff, 16'h000f, 32'hdeadbeef);
    xact(1'b0, 24'h0123ff, 16'h000f, 32'h0);
    xact(1'b1, 24'h456789, 16'h0010, 32'h1);
    xact(1'b0, 24'h456789, 16'hffff, 32'h0);
    xact(1'b1, 24'h4567ff, 16'h0010, 32'h2);
    for (i = 0; i < 40; i++)
      xact(1'($random(seed)), 24'($random(seed)),
           16'($unsigned($random(seed)) % 20), 32'($random(seed)));
    close_out();
  end
endmodule // tile_config_access_protocol_tb
